// ==== dsp_irq_pkg.sv ====
// shared constants for the interrupt and low-power controller
package dsp_irq_pkg;

   // source set, index 0 is the highest priority below reset
   localparam int NSRC = 11;
   localparam int SRC_W = 4;
   localparam int NMASK = 10;
   localparam int VEC_W = 14;
   localparam int SRC_PWRDN = 0;
   localparam int SRC_EXT_IRQ_2 = 1;
   localparam int SRC_LIRQ1 = 2;
   localparam int SRC_LIRQ0 = 3;
   localparam int SRC_S0TX = 4;
   localparam int SRC_S0RX = 5;
   localparam int SRC_EDGE = 6;
   localparam int SRC_BYTE_DMA = 7;
   localparam int SRC_S1TX = 8;
   localparam int SRC_S1RX = 9;
   localparam int SRC_TIMER = 10;

   // vector addresses, same order as the source index
   localparam logic [VEC_W-1:0] VEC_RESET = 14'h0000;
   localparam logic [VEC_W-1:0] VEC_TABLE [NSRC] = '{
      14'h002C, 14'h0004, 14'h0008, 14'h000C, 14'h0010, 14'h0014,
      14'h0018, 14'h001C, 14'h0020, 14'h0024, 14'h0028};

   // control register layout and reset values
   localparam int CTL_W = 5;
   localparam int CTL_EXT_IRQ_0_EDGE = 0;
   localparam int CTL_EXT_IRQ_1_EDGE = 1;
   localparam int CTL_EXT_IRQ_2_EDGE = 2;
   localparam int CTL_NEST = 4;
   localparam logic [CTL_W-1:0] CTL_RESET = 5'h00;
   localparam logic [NMASK-1:0] MASK_RESET = 10'h000;

   // status stack
   localparam int STACK_DEPTH = 12;
   localparam int DEPTH_W = 4;
   localparam int STAT_W = 16;

   // wake-up times in input-clock cycles; processor clock runs at twice
   localparam int MCLK_PER_INPUT_CLOCK = 2;
   localparam int WAKE_FAST_INPUT_CLOCK = 200;
   localparam int WAKE_SLOW_INPUT_CLOCK = 4096;
   localparam int WAKE_FAST_CYC = WAKE_FAST_INPUT_CLOCK * MCLK_PER_INPUT_CLOCK;
   localparam int WAKE_SLOW_CYC = WAKE_SLOW_INPUT_CLOCK * MCLK_PER_INPUT_CLOCK;
   localparam int WAKE_W = 14;

   // slow idle divisor: 16 shifted left by the two-bit code
   localparam int DIV_CODE_W = 2;
   localparam int DIV_BASE_LOG2 = 4;
   localparam int DIV_CNT_W = 7;

   typedef enum logic [1:0] {ST_RUN, ST_IDLE, ST_PWRDN, ST_WAKE} state_e;

endpackage

// ==== clk_div_if.sv ====
// carrier between the controller and its slow idle clock divider
`timescale 1ns/100ps
interface clk_div_if;
   import dsp_irq_pkg::*;
   logic slow;
   logic [DIV_CODE_W-1:0] code;
   logic tick;
   modport ctl (output slow, output code, input tick);
   modport div (input slow, input code, output tick);
endinterface

// ==== slow_clock_divider.sv ====
// processor clock divider producing the slow idle tick
`timescale 1ns/100ps
module slow_clock_divider (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // control from the controller
   clk_div_if.div dv
);
   import dsp_irq_pkg::*;

   logic [DIV_CNT_W-1:0] count;
   wire [DIV_CNT_W-1:0] last;

   // divisor minus one: 15, 31, 63 or 127
   assign last = DIV_CNT_W'((1 << (DIV_BASE_LOG2 + int'(dv.code))) - 1);
   // full rate ticks every cycle, so callers need no special case
   assign dv.tick = !dv.slow || (count == last);

   // free count restarts whenever the divider is idle
   always_ff @(posedge mclk) begin
      if (rst || !dv.slow || dv.tick) begin
         count <= '0;
      end else begin
         count <= count + 1'b1;
      end
   end

endmodule

// ==== dsp_irq_ctrl.sv ====
// interrupt controller, status stack and low-power control
`timescale 1ns/100ps
module dsp_irq_ctrl #(
   parameter int WAKE_SLOW_CYCLES = dsp_irq_pkg::WAKE_SLOW_CYC
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // external interrupt pins, active high
   input wire logic ext_irq_2,
   input wire logic level_irq_1,
   input wire logic level_irq_0,
   input wire logic edge_irq,
   input wire logic ext_irq_1,
   input wire logic ext_irq_0,
   input wire logic serial1_irq_mode,
   // on-chip peripheral request events, latched on the rising edge
   input wire logic serial0_tx_evt,
   input wire logic serial0_rx_evt,
   input wire logic byte_dma_evt,
   input wire logic serial1_tx_evt,
   input wire logic serial1_rx_evt,
   input wire logic timer_evt,
   // register writes from the sequencer
   input wire logic mask_wr,
   input wire logic [dsp_irq_pkg::NMASK-1:0] mask_wdata,
   input wire logic ctrl_wr,
   input wire logic [dsp_irq_pkg::CTL_W-1:0] ctrl_wdata,
   input wire logic fc_wr,
   input wire logic [dsp_irq_pkg::NSRC-1:0] fc_force,
   input wire logic [dsp_irq_pkg::NSRC-1:0] fc_clear,
   input wire logic global_enable_instruction,
   input wire logic global_disable_instruction,
   input wire logic instr_done,
   // vector handshake with the sequencer
   output logic vec_req,
   output logic [dsp_irq_pkg::VEC_W-1:0] vec_addr,
   input wire logic vec_ack,
   input wire logic rti,
   // status stack
   input wire logic [dsp_irq_pkg::STAT_W-1:0] status_in,
   input wire logic nest_push,
   input wire logic nest_pop,
   output logic [dsp_irq_pkg::STAT_W-1:0] status_out,
   output logic stack_empty,
   output logic stack_full,
   output logic stack_overflow,
   // low-power control
   input wire logic power_down_pin,
   input wire logic pd_commit,
   input wire logic osc_off,
   input wire logic power_up_context_bit,
   input wire logic idle_enter,
   input wire logic idle_slow,
   input wire logic [dsp_irq_pkg::DIV_CODE_W-1:0] idle_code,
   output logic power_down_acknowledge,
   output logic halted,
   output logic periph_clk_tick,
   output logic context_cleared,
   // state readback
   output logic [dsp_irq_pkg::NMASK-1:0] interrupt_mask_register,
   output logic [dsp_irq_pkg::CTL_W-1:0] interrupt_control_register,
   output logic [dsp_irq_pkg::NSRC-1:0] pending,
   output logic [dsp_irq_pkg::NSRC-1:0] in_service,
   output logic ints_enabled
);
   import dsp_irq_pkg::*;

   state_e state;
   state_e next_state;
   logic [NSRC-1:0] src_prev;
   logic mask_block;
   logic rst_pend;
   logic vec_is_rst;
   logic [SRC_W-1:0] vec_idx;
   logic [WAKE_W-1:0] wake_cnt;
   logic slow_q;
   logic [DIV_CODE_W-1:0] code_q;
   logic [DEPTH_W-1:0] depth;
   logic [STAT_W-1:0] stack [STACK_DEPTH];
   logic [SRC_W-1:0] sel_idx;
   logic sel_any;

   wire [NSRC-1:0] src_in;
   wire [NSRC-1:0] is_level;
   wire [NSRC-1:0] rise;
   wire [NSRC-1:0] set_req;
   wire [NSRC-1:0] clr_req;
   wire [NSRC-1:0] req;
   wire [NSRC-1:0] unmasked;
   wire [NSRC-1:0] busy_upto;
   wire [NSRC-1:0] elig;
   wire [NSRC-1:0] serv;
   wire [NSRC-1:0] ack_src;
   wire [NSRC-1:0] rti_clr;
   wire nest_mode;
   wire gate;
   wire ack_take;
   wire push;
   wire pop;
   wire pin_fall;
   wire wake_done;
   wire ctx_clr;

   clk_div_if dv ();

   slow_clock_divider u_div (
      .mclk(mclk),
      .rst(rst),
      .dv(dv)
   );

   // divider runs slow only while parked in slow idle
   assign dv.slow = (state == ST_IDLE) && slow_q;
   assign dv.code = code_q;
   assign periph_clk_tick = dv.tick;

   // raw request per source, serial1 lines shared with two pins
   assign src_in[SRC_PWRDN] = power_down_pin;
   assign src_in[SRC_EXT_IRQ_2] = ext_irq_2;
   assign src_in[SRC_LIRQ1] = level_irq_1;
   assign src_in[SRC_LIRQ0] = level_irq_0;
   assign src_in[SRC_S0TX] = serial0_tx_evt;
   assign src_in[SRC_S0RX] = serial0_rx_evt;
   assign src_in[SRC_EDGE] = edge_irq;
   assign src_in[SRC_BYTE_DMA] = byte_dma_evt;
   assign src_in[SRC_S1TX] = serial1_irq_mode ? ext_irq_1 : serial1_tx_evt;
   assign src_in[SRC_S1RX] = serial1_irq_mode ? ext_irq_0 : serial1_rx_evt;
   assign src_in[SRC_TIMER] = timer_evt;

   // sensing per source; power-down and edge_irq are always edge
   assign is_level[SRC_PWRDN] = 1'b0;
   assign is_level[SRC_EXT_IRQ_2] =
      !interrupt_control_register[CTL_EXT_IRQ_2_EDGE];
   assign is_level[SRC_LIRQ1] = 1'b1;
   assign is_level[SRC_LIRQ0] = 1'b1;
   assign is_level[SRC_S0TX] = 1'b0;
   assign is_level[SRC_S0RX] = 1'b0;
   assign is_level[SRC_EDGE] = 1'b0;
   assign is_level[SRC_BYTE_DMA] = 1'b0;
   assign is_level[SRC_S1TX] = serial1_irq_mode &&
      !interrupt_control_register[CTL_EXT_IRQ_1_EDGE];
   assign is_level[SRC_S1RX] = serial1_irq_mode &&
      !interrupt_control_register[CTL_EXT_IRQ_0_EDGE];
   assign is_level[SRC_TIMER] = 1'b0;

   // latch control; software and acknowledge both clear, sets win
   assign rise = src_in & ~src_prev;
   assign set_req = (rise & ~is_level)
      | (fc_force & {NSRC{fc_wr}});
   assign clr_req = (fc_clear & {NSRC{fc_wr}}) | ack_src;
   assign req = pending | (src_in & is_level);

   // mask bit k gates source k+1; power-down has no mask bit
   assign unmasked = req & {interrupt_mask_register, 1'b1};

   // prefix of in-service bits at or above each priority
   genvar gi;
   generate
      for (gi = 0; gi < NSRC; gi++) begin : g_src
         if (gi == 0) begin : g_top
            assign busy_upto[gi] = in_service[gi];
         end else begin : g_rest
            assign busy_upto[gi] = in_service[gi] | busy_upto[gi-1];
         end
         // nested: only strictly higher than the running level wins
         assign elig[gi] = unmasked[gi] &&
            (nest_mode ? !busy_upto[gi] : !(|in_service));
      end
   endgenerate

   assign nest_mode = interrupt_control_register[CTL_NEST];
   assign gate = ints_enabled && !mask_block;
   assign serv = elig & {NSRC{gate}};

   // lowest index wins, which is the fixed priority order
   always_comb begin
      sel_idx = '0;
      sel_any = 1'b0;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (serv[i]) begin
            sel_idx = SRC_W'(i);
            sel_any = 1'b1;
         end
      end
   end

   // handshake, stack and return decode
   assign ack_take = vec_ack && vec_req;
   assign ack_src = (ack_take && !vec_is_rst) ?
      NSRC'(1) << vec_idx : '0;
   assign rti_clr = in_service & ~(in_service - 1'b1);
   assign push = ack_take || nest_push;
   assign pop = (rti || nest_pop) && !push;
   assign stack_empty = (depth == '0);
   assign stack_full = (depth == DEPTH_W'(STACK_DEPTH));
   assign pin_fall = src_prev[SRC_PWRDN] && !power_down_pin;
   assign wake_done = (state == ST_WAKE) && (wake_cnt == '0);
   assign ctx_clr = wake_done && power_up_context_bit;

   // low-power sequencing
   always_comb begin
      next_state = state;
      case (state)
         ST_RUN: begin
            if (pd_commit) begin
               next_state = ST_PWRDN;
            end else if (idle_enter) begin
               next_state = ST_IDLE;
            end
         end
         ST_IDLE: begin
            // a slow tick bounds the exit to one divisor period
            if ((sel_any || rst_pend) && dv.tick) begin
               next_state = ST_RUN;
            end
         end
         ST_PWRDN: begin
            if (pin_fall) begin
               next_state = ST_WAKE;
            end
         end
         ST_WAKE: begin
            if (wake_cnt == '0) begin
               next_state = ST_RUN;
            end
         end
         default: begin
            next_state = ST_RUN;
         end
      endcase
   end

   // state and low-power outputs; reset also ends power-down
   always_ff @(posedge mclk) begin
      if (rst) begin
         state <= ST_RUN;
         power_down_acknowledge <= 1'b0;
         halted <= 1'b0;
         context_cleared <= 1'b0;
      end else begin
         state <= next_state;
         power_down_acknowledge <= (next_state == ST_PWRDN);
         halted <= (next_state != ST_RUN);
         context_cleared <= ctx_clr;
      end
   end

   // wake counter; the slow count is a parameter to allow short runs
   always_ff @(posedge mclk) begin
      if (rst) begin
         wake_cnt <= '0;
      end else if (state == ST_PWRDN) begin
         wake_cnt <= osc_off ? WAKE_W'(WAKE_SLOW_CYCLES - 1)
            : WAKE_W'(WAKE_FAST_CYC - 1);
      end else if (wake_cnt != '0) begin
         wake_cnt <= wake_cnt - 1'b1;
      end
   end

   // idle mode captured from the instruction
   always_ff @(posedge mclk) begin
      if (rst) begin
         slow_q <= 1'b0;
         code_q <= '0;
      end else if (state == ST_RUN && idle_enter) begin
         slow_q <= idle_slow;
         code_q <= idle_code;
      end
   end

   // configuration registers and the global enable
   always_ff @(posedge mclk) begin
      if (rst) begin
         interrupt_mask_register <= MASK_RESET;
         interrupt_control_register <= CTL_RESET;
         ints_enabled <= 1'b1;
      end else begin
         if (mask_wr) begin
            interrupt_mask_register <= mask_wdata;
         end
         if (ctrl_wr) begin
            interrupt_control_register <= ctrl_wdata;
         end
         if (global_disable_instruction) begin
            ints_enabled <= 1'b0;
         end else if (global_enable_instruction) begin
            ints_enabled <= 1'b1;
         end
      end
   end

   // block from the mask write until the next instruction completes
   always_ff @(posedge mclk) begin
      if (rst) begin
         mask_block <= 1'b0;
      end else if (mask_wr) begin
         mask_block <= 1'b1;
      end else if (instr_done) begin
         mask_block <= 1'b0;
      end
   end

   // pending latches and edge history; context clear wipes requests
   always_ff @(posedge mclk) begin
      if (rst) begin
         src_prev <= '0;
         pending <= '0;
      end else begin
         src_prev <= src_in;
         if (ctx_clr) begin
            // a request that lands in the clear cycle still survives
            pending <= set_req;
         end else begin
            pending <= set_req | (pending & ~clr_req);
         end
      end
   end

   // reset vector request and in-service levels
   always_ff @(posedge mclk) begin
      if (rst) begin
         rst_pend <= 1'b1;
         in_service <= '0;
      end else if (ctx_clr) begin
         rst_pend <= 1'b1;
         in_service <= '0;
      end else begin
         if (ack_take && vec_is_rst) begin
            rst_pend <= 1'b0;
         end
         in_service <= (in_service & ~(rti ? rti_clr : '0)) | ack_src;
      end
   end

   // vector output; dropped for one cycle after each acknowledge
   always_ff @(posedge mclk) begin
      if (rst) begin
         vec_req <= 1'b0;
         vec_addr <= VEC_RESET;
         vec_is_rst <= 1'b0;
         vec_idx <= '0;
      end else begin
         vec_req <= (next_state == ST_RUN) && !vec_ack
            && (rst_pend || sel_any);
         vec_addr <= rst_pend ? VEC_RESET : VEC_TABLE[sel_idx];
         vec_is_rst <= rst_pend;
         vec_idx <= sel_idx;
      end
   end

   // shared status stack; a full stack refuses the push and flags it
   always_ff @(posedge mclk) begin
      if (rst) begin
         depth <= '0;
         stack_overflow <= 1'b0;
         status_out <= '0;
      end else if (ctx_clr) begin
         depth <= '0;
      end else if (push) begin
         if (!stack_full) begin
            stack[depth] <= status_in;
            depth <= depth + 1'b1;
         end else begin
            stack_overflow <= 1'b1;
         end
      end else if (pop && !stack_empty) begin
         status_out <= stack[depth - 1'b1];
         depth <= depth - 1'b1;
      end
   end

endmodule

// ==== dsp_irq_ctrl_properties.sv ====
// concurrent checks on the interrupt controller top ports
`timescale 1ns/100ps
module dsp_irq_ctrl_properties import dsp_irq_pkg::*; #(
   parameter int WAKE_SLOW_CYCLES = dsp_irq_pkg::WAKE_SLOW_CYC
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // stimulus side
   input wire logic mask_wr,
   input wire logic nest_push,
   input wire logic power_down_pin,
   input wire logic pd_commit,
   input wire logic osc_off,
   input wire logic vec_ack,
   // design outputs
   input wire logic vec_req,
   input wire logic [dsp_irq_pkg::VEC_W-1:0] vec_addr,
   input wire logic [dsp_irq_pkg::NSRC-1:0] pending,
   input wire logic stack_empty,
   input wire logic stack_full,
   input wire logic stack_overflow,
   input wire logic power_down_acknowledge,
   input wire logic halted,
   input wire logic periph_clk_tick,
   input wire logic ints_enabled
);
   logic waking;
   logic [13:0] wake_cnt;

   default clocking @(posedge mclk); endclocking
   default disable iff (rst);

   // cycles spent halted after power-down ends; idle never sets waking
   always_ff @(posedge mclk) begin
      if (rst || !halted) begin
         waking <= 1'b0;
         wake_cnt <= 14'h0000;
      end else begin
         if (power_down_acknowledge) waking <= 1'b1;
         if (waking && !power_down_acknowledge) wake_cnt <= wake_cnt + 14'h1;
      end
   end

   vec_in_table_a: assert property (
      vec_req |-> vec_addr == VEC_RESET || vec_addr inside {VEC_TABLE})
      else $error("vector address outside the table");
   reset_vector_a: assert property (
      $fell(rst) |-> ##[1:2] (vec_req && vec_addr == VEC_RESET))
      else $error("no reset vector after reset");
   reset_state_a: assert property (
      $fell(rst) |-> ints_enabled && pending == '0 && stack_empty
         && !power_down_acknowledge)
      else $error("wrong state after reset");
   disabled_gate_a: assert property (
      !ints_enabled [*2] |-> !vec_req || vec_addr == VEC_RESET)
      else $error("vector while servicing disabled");
   mask_block_a: assert property (
      mask_wr |-> ##2 (!$rose(vec_req) || vec_addr == VEC_RESET))
      else $error("vector right after mask write");
   pd_ack_a: assert property (
      pd_commit && !halted |=> power_down_acknowledge && halted)
      else $error("no acknowledge after commit");
   pd_exit_a: assert property (
      power_down_acknowledge && $fell(power_down_pin)
         |=> !power_down_acknowledge && halted)
      else $error("power-down exit not taken");
   wake_time_a: assert property (
      $fell(halted) && waking
         |-> wake_cnt == 14'(osc_off ? WAKE_SLOW_CYCLES : WAKE_FAST_CYC))
      else $error("wrong wake-up time");
   overflow_a: assert property (
      stack_full && nest_push |=> stack_overflow && stack_full)
      else $error("overflow not flagged");
   ack_push_a: assert property (
      vec_req && vec_ack && !stack_full |=> !stack_empty && !vec_req)
      else $error("ack did not push or release");
   tick_run_a: assert property (
      !halted |-> periph_clk_tick)
      else $error("tick missing at full rate");
endmodule

bind dsp_irq_ctrl dsp_irq_ctrl_properties #(
   .WAKE_SLOW_CYCLES(WAKE_SLOW_CYCLES)
) i_dsp_irq_ctrl_properties (
   .mclk(mclk), .rst(rst), .mask_wr(mask_wr), .nest_push(nest_push),
   .power_down_pin(power_down_pin), .pd_commit(pd_commit),
   .osc_off(osc_off), .vec_ack(vec_ack), .vec_req(vec_req),
   .vec_addr(vec_addr), .pending(pending), .stack_empty(stack_empty),
   .stack_full(stack_full), .stack_overflow(stack_overflow),
   .power_down_acknowledge(power_down_acknowledge), .halted(halted),
   .periph_clk_tick(periph_clk_tick), .ints_enabled(ints_enabled)
);

// ==== irq_seq_model.sv ====
// sequencer stand-in that takes vectors from the controller
`timescale 1ns/100ps
module irq_seq_model import dsp_irq_pkg::*; (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // vector handshake
   input wire logic vec_req,
   input wire logic [dsp_irq_pkg::VEC_W-1:0] vec_addr,
   output logic vec_ack,
   // test control and record
   input wire logic hold,
   input wire logic [3:0] lag,
   output logic [dsp_irq_pkg::VEC_W-1:0] last_vec,
   output logic [7:0] taken
);
   logic [3:0] wait_cnt;

   // answer a standing request after lag cycles; hold withholds it
   always_ff @(posedge mclk) begin
      if (rst) begin
         vec_ack <= 1'b0;
         wait_cnt <= 4'h0;
         taken <= 8'h00;
         last_vec <= '0;
      end else if (vec_ack && vec_req) begin
         vec_ack <= 1'b0;
         wait_cnt <= 4'h0;
         last_vec <= vec_addr;
         taken <= taken + 8'h01;
      end else if (vec_req && !hold) begin
         wait_cnt <= wait_cnt + 4'h1;
         vec_ack <= (wait_cnt >= lag);
      end else begin
         vec_ack <= 1'b0;
         wait_cnt <= 4'h0;
      end
   end
endmodule

// ==== dsp_irq_ctrl_bench.sv ====
// self-checking bench for the interrupt and low-power controller
`timescale 1ns/100ps
module dsp_irq_ctrl_bench;
   import dsp_irq_pkg::*;
   localparam int SLOW = 20;
   localparam int MW = 0, CW = 1, FW = 2, GE = 3, GD = 4, RT = 5;
   localparam int PU = 6, PO = 7, PC = 8, IE = 9;
   logic mclk, rst, s1_mode, idone, pd_pin, osc_off, ctx_bit, idle_slow;
   logic hold, vec_req, vec_ack, s_empty, s_full, s_ovf, pd_ack, halted;
   logic tick, ctx_clr, ints_en;
   logic [9:0] pl;
   logic [NSRC-1:0] src, fc_force, fc_clear, pending, in_service;
   logic [NMASK-1:0] mask_d, mask_q;
   logic [CTL_W-1:0] ctrl_d, ctrl_q;
   logic [VEC_W-1:0] vec_addr, last_vec;
   logic [STAT_W-1:0] stat_in, stat_out;
   logic [1:0] code;
   logic [3:0] lag;
   logic [7:0] taken;
   int err_total, comparisons;

   dsp_irq_ctrl #(.WAKE_SLOW_CYCLES(SLOW)) i_dsp_irq_ctrl (
      .mclk(mclk), .rst(rst), .ext_irq_2(src[1]), .level_irq_1(src[2]),
      .level_irq_0(src[3]), .edge_irq(src[6]), .ext_irq_1(src[8]),
      .ext_irq_0(src[9]), .serial1_irq_mode(s1_mode),
      .serial0_tx_evt(src[4]), .serial0_rx_evt(src[5]),
      .byte_dma_evt(src[7]), .serial1_tx_evt(src[8]),
      .serial1_rx_evt(src[9]), .timer_evt(src[10]),
      .mask_wr(pl[MW]), .mask_wdata(mask_d), .ctrl_wr(pl[CW]),
      .ctrl_wdata(ctrl_d), .fc_wr(pl[FW]), .fc_force(fc_force),
      .fc_clear(fc_clear), .global_enable_instruction(pl[GE]),
      .global_disable_instruction(pl[GD]), .instr_done(idone),
      .vec_req(vec_req), .vec_addr(vec_addr), .vec_ack(vec_ack),
      .rti(pl[RT]), .status_in(stat_in), .nest_push(pl[PU]),
      .nest_pop(pl[PO]), .status_out(stat_out), .stack_empty(s_empty),
      .stack_full(s_full), .stack_overflow(s_ovf),
      .power_down_pin(pd_pin), .pd_commit(pl[PC]), .osc_off(osc_off),
      .power_up_context_bit(ctx_bit), .idle_enter(pl[IE]),
      .idle_slow(idle_slow), .idle_code(code),
      .power_down_acknowledge(pd_ack), .halted(halted),
      .periph_clk_tick(tick), .context_cleared(ctx_clr),
      .interrupt_mask_register(mask_q), .interrupt_control_register(ctrl_q),
      .pending(pending), .in_service(in_service), .ints_enabled(ints_en)
   );

   irq_seq_model i_irq_seq_model (
      .mclk(mclk), .rst(rst), .vec_req(vec_req), .vec_addr(vec_addr),
      .vec_ack(vec_ack), .hold(hold), .lag(lag), .last_vec(last_vec),
      .taken(taken)
   );

   // 200 MHz clock
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   task automatic tally_and_finish();
      $display("comparisons %0d, mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask

   task automatic test_end(input string name);
      $display("test %s done, mismatches %0d", name, err_total);
   endtask

   // one-cycle strobe, then a spare cycle so strobes never abut
   task automatic pulse(input int k);
      pl[k] = 1'b1;
      cyc(1);
      pl = '0;
      cyc(1);
   endtask

   task automatic wreg(input int k, input logic [10:0] d, logic [10:0] c);
      mask_d = d[9:0];
      ctrl_d = d[4:0];
      fc_force = d;
      fc_clear = c;
      pulse(k);
   endtask

   // wait for the sequencer model to take a vector, then compare it
   task automatic wait_vec(input logic [VEC_W-1:0] exp);
      logic [7:0] t0;
      int i;
      t0 = taken;
      i = 0;
      while (taken === t0 && i < 600) begin
         cyc(1);
         i++;
      end
      if (i == 600) begin
         err_total++;
         tally_and_finish();
      end else begin
         chk(16'(last_vec), 16'(exp));
      end
   endtask

   task automatic serve(input int k);
      src[k] = 1'b1;
      wait_vec(VEC_TABLE[k]);
      src[k] = 1'b0;
      pulse(RT);
   endtask

   task automatic reset_run();
      rst = 1'b1;
      cyc(4);
      rst = 1'b0;
   endtask

   // main sequence
   initial begin
      int n;
      int ord[3];
      ord = '{2, 4, 10};
      {rst, s1_mode, pd_pin, osc_off, ctx_bit, idle_slow} = 6'b100000;
      {src, fc_force, fc_clear, pl, mask_d, ctrl_d, code} = '0;
      {idone, hold, lag, stat_in} = {2'b11, 4'h0, 16'h0000};
      reset_run();
      for (int i = 0; i < STACK_DEPTH; i++) begin
         stat_in = 16'h1000 + 16'(i);
         pulse(PU);
      end
      chk(s_full, 1'b1);
      stat_in = 16'hDEAD;
      pulse(PU);
      chk(s_ovf, 1'b1);
      for (int i = STACK_DEPTH - 1; i >= 0; i--) begin
         pulse(PO);
         chk(stat_out, 16'h1000 + 16'(i));
      end
      chk(s_empty, 1'b1);
      hold = 1'b0;
      wait_vec(VEC_RESET);
      chk({mask_q, ctrl_q, ints_en}, {MASK_RESET, CTL_RESET, 1'b1});
      test_end("reset and stack");
      wreg(MW, 11'h3FF, 11'h000);
      for (int k = 1; k < NSRC; k++) begin
         s1_mode = (k == 9);
         serve(k);
      end
      src = 11'h414;
      for (int j = 0; j < 3; j++) begin
         wait_vec(VEC_TABLE[ord[j]]);
         src = '0;
         pulse(RT);
      end
      test_end("vectors and priority");
      wreg(MW, 11'h1FF, 11'h000);
      src[10] = 1'b1;
      cyc(20);
      chk({vec_req, pending[10]}, 2'b01);
      src[10] = 1'b0;
      wreg(MW, 11'h3FF, 11'h000);
      wait_vec(VEC_TABLE[10]);
      pulse(RT);
      pulse(GD);
      src = 11'h402;
      cyc(3);
      src = '0;
      cyc(20);
      chk({vec_req, ints_en, pending[10], pending[1]}, 4'b0010);
      wreg(FW, 11'h0C0, 11'h000);
      wreg(FW, 11'h000, 11'h080);
      chk(pending[7:6], 2'b01);
      pulse(GE);
      wait_vec(VEC_TABLE[6]);
      pulse(RT);
      wait_vec(VEC_TABLE[10]);
      pulse(RT);
      wreg(CW, 11'h014, 11'h000);
      pulse(GD);
      src[1] = 1'b1;
      cyc(3);
      src[1] = 1'b0;
      pulse(GE);
      wait_vec(VEC_TABLE[1]);
      pulse(RT);
      src[10] = 1'b1;
      wait_vec(VEC_TABLE[10]);
      src = 11'h002;
      wait_vec(VEC_TABLE[1]);
      src = '0;
      pulse(RT);
      pulse(RT);
      chk(in_service, 16'h0000);
      test_end("mask, enable, force and nesting");
      lag = 4'h3;
      for (int c = 0; c < 4; c++) begin
         idle_slow = 1'b1;
         code = 2'(c);
         pulse(IE);
         chk(halted, 1'b1);
         n = 0;
         repeat (16 << c) begin
            if (tick === 1'b1) n++;
            cyc(1);
         end
         chk(16'(n), 16'h0001);
         src[10] = 1'b1;
         n = 0;
         while (vec_req !== 1'b1 && n < 200) begin
            cyc(1);
            n++;
         end
         chk(16'(n <= (16 << c) + 3), 16'h0001);
         wait_vec(VEC_TABLE[10]);
         src[10] = 1'b0;
         pulse(RT);
      end
      test_end("idle");
      wreg(MW, 11'h000, 11'h000);
      pd_pin = 1'b1;
      wait_vec(VEC_TABLE[0]);
      cyc(5);
      chk(pd_ack, 1'b0);
      pulse(PC);
      chk({pd_ack, halted}, 2'b11);
      pd_pin = 1'b0;
      cyc(395);
      chk(halted, 1'b1);
      cyc(10);
      chk(halted, 1'b0);
      pulse(RT);
      {osc_off, ctx_bit} = 2'b11;
      wreg(FW, 11'h001, 11'h000);
      wait_vec(VEC_TABLE[0]);
      pulse(PC);
      pd_pin = 1'b1;
      cyc(2);
      pd_pin = 1'b0;
      n = 0;
      for (int i = 0; i < SLOW + 10; i++) begin
         if (ctx_clr === 1'b1) n++;
         cyc(1);
      end
      chk(16'(n), 16'h0001);
      cyc(10);
      chk({last_vec, in_service}, {VEC_RESET, 11'h000});
      {osc_off, ctx_bit, pd_pin} = 3'b001;
      wait_vec(VEC_TABLE[0]);
      pulse(PC);
      reset_run();
      chk({pd_ack, halted}, 2'b00);
      wait_vec(VEC_RESET);
      test_end("power-down");
      tally_and_finish();
   end
endmodule
